// ---- hw/flash_ctl_pkg.sv ----
// Purpose: shared constants and carriers for the flash command controller
// Assumes: host-side controller driving an asynchronous parallel flash
// Notes: command words and unlock addresses in word and byte mode
package flash_ctl_pkg;
  // controller register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RDAT = 8'h10;
  // control field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 4;
  localparam int CTRL_BYTE = 8;
  // status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_TMO = 2;
  localparam int STAT_ERR = 3;
  // command data values
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  // unlock addresses, word and byte mode
  localparam logic [19:0] ADR_W1 = 20'h00555;
  localparam logic [19:0] ADR_W2 = 20'h002AA;
  localparam logic [19:0] ADR_B1 = 20'h00AAA;
  localparam logic [19:0] ADR_B2 = 20'h00555;
  localparam int SECTOR_MSB = 19;
  localparam int SECTOR_LSB = 12;
  // status bit positions on the data bus
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  // bus strobe and suspend wait timing, control reset value
  localparam int STROBE_NS = 80;
  localparam int CLK_NS = 10;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSPEND_US = 20;
  localparam int SUSPEND_CYC = SUSPEND_US * 1000 / CLK_NS;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // controller operations
  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM, OP_CHIP_ERASE,
    OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_POLL
  } op_t;
  // flash pin group, controller side
  typedef struct packed {
    logic ceN;
    logic weN;
    logic oeN;
    logic byteN;
    logic [19:0] addr;
    logic [15:0] dout;
    logic doutEnN;
  } flash_pins_t;
  // one bus cycle request to the pin engine
  typedef struct packed {
    logic wr;
    logic [19:0] addr;
    logic [15:0] data;
  } cycle_req_t;
endpackage : flash_ctl_pkg

// ---- hw/flash_bus_cycle.sv ----
// Purpose: one asynchronous flash read or write cycle from a request
// Assumes: request held stable while busy is high
// Notes: ce and we fall together, data stands past their rise
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle #(
  parameter int STROBE = flash_ctl_pkg::STROBE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic start,
  input wire flash_ctl_pkg::cycle_req_t req,
  input wire logic [15:0] dinSync,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic ceN,
  output logic weN,
  output logic oeN,
  output logic [19:0] addr,
  output logic [15:0] dout,
  output logic doutEnN
);
  import flash_ctl_pkg::*;
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} cyc_t;
  cyc_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  wire strobeEnd = (cnt_q == 8'(STROBE));
  // sequencing of one cycle; address set before strobes fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= CY_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      ceN <= 1'b1;
      weN <= 1'b1;
      oeN <= 1'b1;
      addr <= 20'h00000;
      dout <= 16'h0000;
      doutEnN <= 1'b1;
    end else if (clkEn) begin
      done <= 1'b0;
      case (st_q)
        CY_IDLE: begin
          if (start) begin
            st_q <= CY_SETUP;
            busy <= 1'b1;
            wr_q <= req.wr;
            addr <= req.addr;
            dout <= req.data;
            doutEnN <= ~req.wr;
          end
        end
        CY_SETUP: begin
          // write: ce and we low with oe high; read: oe low, we high
          ceN <= 1'b0;
          weN <= ~wr_q;
          oeN <= wr_q;
          cnt_q <= 8'h00;
          st_q <= CY_STROBE;
        end
        CY_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (strobeEnd) begin
            // both rise together so data latches at this edge
            ceN <= 1'b1;
            weN <= 1'b1;
            oeN <= 1'b1;
            if (!wr_q) begin
              rdata <= dinSync;
            end
            st_q <= CY_HOLD;
          end
        end
        default: begin
          doutEnN <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
          st_q <= CY_IDLE;
        end
      endcase
    end
  end
endmodule : flash_bus_cycle
`default_nettype wire

// ---- hw/flash_command_ctl.sv ----
// Purpose: AHB-Lite controlled host sequencer for a parallel NOR flash
// Assumes: one flash on dedicated pins; hsel always decoded upstream
// Notes: poll op reads until toggle bit stands still or timeout shows
// Operation
// - host writes reset after timeout flag or to leave autoselect
// - program is four writes: two unlocks, setup, address and data
// - chip erase is six writes ending with chip erase code
// - sector erase is six writes, last one at the sector address
// - unlock pair AA 55 then operation code for autoselect, program and erase; reset, suspend and resume are one write
// - write only with chip-select and write-strobe low, output-enable high
`timescale 1ns/100ps
`default_nettype none
module flash_command_ctl #(
  parameter int SUSPEND_WAIT = flash_ctl_pkg::SUSPEND_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] flashDin,
  output flash_ctl_pkg::flash_pins_t flashPins
);
  import flash_ctl_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_NEXT, S_PAUSE
  } seq_t;
  // program registers
  logic [31:0] ctrl_q;
  logic [19:0] addr_q;
  logic [15:0] data_q;
  logic [15:0] rdat_q;
  logic busy_q, done_q, tmo_q, err_q;
  seq_t st_q;
  logic [2:0] idx_q, last_q;
  logic [15:0] prevRd_q;
  logic pollFirst_q;
  logic [31:0] wait_q;
  // ahb address phase capture
  logic wrPend_q, rdPend_q;
  logic [7:0] ofs_q;
  // pin synchroniser, first stage read only by second
  logic [15:0] dinMeta_q, dinSync_q;
  logic cycStart_q;
  cycle_req_t cycReq;
  logic cycBusy, cycDone;
  logic [15:0] cycRdata;
  logic ceN, weN, oeN, doutEnN;
  logic [19:0] pinAddr;
  logic [15:0] pinDout;
  wire byteMode = ctrl_q[CTRL_BYTE];
  wire op_t op = op_t'(ctrl_q[CTRL_OP_LSB +: 4]);
  wire goWr = wrPend_q && (ofs_q == OFS_CTRL) && hwdata[CTRL_GO];
  wire addrPhase = hsel && htrans[1] && hready;
  // address and data of step i of the current command sequence
  function automatic cycle_req_t stepOf(input op_t o, input logic [2:0] i,
                                        input logic bm, input logic [19:0] a,
                                        input logic [15:0] d);
    cycle_req_t r;
    logic [19:0] u1, u2;
    r.wr = 1'b1;
    u1 = bm ? ADR_B1 : ADR_W1;
    u2 = bm ? ADR_B2 : ADR_W2;
    r.addr = u1;
    r.data = {8'h00, CMD_UNLOCK1};
    // steps follow the defined sequences so no write aborts one
    case (i)
      3'd1: begin
        r.addr = u2;
        r.data = {8'h00, CMD_UNLOCK2};
      end
      3'd2: r.data = {8'h00, (o == OP_AUTOSEL) ? CMD_AUTOSEL :
                      (o == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP};
      3'd3: begin
        if (o == OP_PROGRAM) begin
          r.addr = a;
          r.data = bm ? {8'h00, d[7:0]} : d;
        end
      end
      3'd4: begin
        r.addr = u2;
        r.data = {8'h00, CMD_UNLOCK2};
      end
      3'd5: begin
        if (o == OP_SECTOR_ERASE) begin
          // only the sector field matters to the flash
          r.addr = {a[SECTOR_MSB:SECTOR_LSB], 12'h000};
          r.data = {8'h00, CMD_SECTOR_ERASE};
        end else begin
          r.data = {8'h00, CMD_CHIP_ERASE};
        end
      end
      default: ;
    endcase
    // single-write commands and plain reads
    if (o == OP_RESET) begin
      r.data = {8'h00, CMD_RESET};
    end else if (o == OP_SUSPEND) begin
      r.data = {8'h00, CMD_SUSPEND};
    end else if (o == OP_RESUME) begin
      r.data = {8'h00, CMD_RESUME};
    end else if (o == OP_READ || o == OP_POLL) begin
      r.wr = 1'b0;
      r.addr = a;
    end
    return r;
  endfunction : stepOf
  // number of the last step per operation
  function automatic logic [2:0] lastOf(input op_t o);
    case (o)
      OP_AUTOSEL: return 3'd2;
      OP_PROGRAM: return 3'd3;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: return 3'd5;
      default: return 3'd0;
    endcase
  endfunction : lastOf
  // program never sets a bit; an odd request is flagged as an error
  wire progBad = (op == OP_PROGRAM) &&
                 ((data_q & ~rdat_q) != 16'h0000);
  assign cycReq = stepOf(op, idx_q, byteMode, addr_q, data_q);
  // toggle bit moves while embedded work runs
  wire toggling = (cycRdata[TOGGLE_BIT] != prevRd_q[TOGGLE_BIT]);
  wire timedOut = cycRdata[TIMEOUT_BIT];
  flash_bus_cycle u_cycle (
    .mclk(mclk),
    .rst(rst),
    .clkEn(clkEn),
    .start(cycStart_q),
    .req(cycReq),
    .dinSync(dinSync_q),
    .busy(cycBusy),
    .done(cycDone),
    .rdata(cycRdata),
    .ceN(ceN),
    .weN(weN),
    .oeN(oeN),
    .addr(pinAddr),
    .dout(pinDout),
    .doutEnN(doutEnN)
  );
  // data pins synchronised since they change off this clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      dinMeta_q <= 16'h0000;
      dinSync_q <= 16'h0000;
    end else if (clkEn) begin
      dinMeta_q <= flashDin;
      dinSync_q <= dinMeta_q;
    end
  end
  // ahb slave, zero wait state, always okay
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      ofs_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= CTRL_RESET;
      addr_q <= 20'h00000;
      data_q <= 16'h0000;
    end else if (clkEn) begin
      wrPend_q <= addrPhase && hwrite;
      rdPend_q <= addrPhase && !hwrite;
      ofs_q <= haddr[7:0];
      if (wrPend_q && !busy_q) begin
        // writes while a sequence runs are dropped
        if (ofs_q == OFS_CTRL) begin
          ctrl_q <= hwdata & ~(32'h1 << CTRL_GO);
        end else if (ofs_q == OFS_ADDR) begin
          addr_q <= hwdata[19:0];
        end else if (ofs_q == OFS_DATA) begin
          data_q <= hwdata[15:0];
        end
      end
      if (addrPhase && !hwrite) begin
        if (haddr[7:0] == OFS_CTRL) begin
          hrdata <= ctrl_q;
        end else if (haddr[7:0] == OFS_ADDR) begin
          hrdata <= {12'h000, addr_q};
        end else if (haddr[7:0] == OFS_DATA) begin
          hrdata <= {16'h0000, data_q};
        end else if (haddr[7:0] == OFS_STAT) begin
          hrdata <= {28'h0, err_q, tmo_q, done_q, busy_q};
        end else if (haddr[7:0] == OFS_RDAT) begin
          hrdata <= {16'h0000, rdat_q};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end
  // sequencer: issues the steps, then polls or waits as the op needs
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= S_IDLE;
      idx_q <= 3'd0;
      last_q <= 3'd0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      tmo_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 16'h0000;
      prevRd_q <= 16'h0000;
      pollFirst_q <= 1'b0;
      wait_q <= 32'h0;
      cycStart_q <= 1'b0;
    end else if (clkEn) begin
      cycStart_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (goWr && !busy_q) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            err_q <= 1'b0;
            idx_q <= 3'd0;
            last_q <= lastOf(op_t'(hwdata[CTRL_OP_LSB +: 4]));
            pollFirst_q <= 1'b1;
            st_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (progBad && idx_q == 3'd0) begin
            // refuse rather than rely on the flash timing out
            err_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            cycStart_q <= 1'b1;
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (cycDone) begin
            st_q <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (idx_q != last_q) begin
            idx_q <= idx_q + 3'd1;
            st_q <= S_ISSUE;
          end else if (op == OP_POLL) begin
            prevRd_q <= cycRdata;
            pollFirst_q <= 1'b0;
            if (!pollFirst_q && !toggling) begin
              // flash went back to read array on its own
              rdat_q <= cycRdata;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end else if (!pollFirst_q && timedOut) begin
              tmo_q <= 1'b1;
              rdat_q <= cycRdata;
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end else begin
              st_q <= S_ISSUE;
            end
          end else if (op == OP_SUSPEND) begin
            wait_q <= 32'(SUSPEND_WAIT);
            st_q <= S_PAUSE;
          end else begin
            if (op == OP_RESET) begin
              tmo_q <= 1'b0;
            end
            rdat_q <= cycRdata;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_PAUSE: begin
          if (wait_q == 32'h0) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // pins registered once more after the cycle engine flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      flashPins <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, byteN: 1'b1,
                     addr: 20'h0, dout: 16'h0, doutEnN: 1'b1};
    end else if (clkEn) begin
      flashPins.ceN <= ceN;
      flashPins.weN <= weN;
      flashPins.oeN <= oeN;
      flashPins.byteN <= ~byteMode;
      flashPins.addr <= pinAddr;
      flashPins.dout <= pinDout;
      flashPins.doutEnN <= doutEnN;
    end
  end
  // a write strobe never overlaps output enable
  strobe_excl_a: assert property (@(posedge mclk) disable iff (rst)
    !flashPins.weN |-> flashPins.oeN && !flashPins.ceN)
    else $error("write strobe with output enable low");
  // data driven in the cycle before the write strobe rises
  data_drive_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(flashPins.weN) |-> !$past(flashPins.doutEnN))
    else $error("data not driven at write strobe rise");
  // address stable across a strobe
  addr_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !flashPins.ceN && !$past(flashPins.ceN) |->
    flashPins.addr == $past(flashPins.addr))
    else $error("address moved during strobe");
  // a start leads to a completed cycle in bounded time
  cycle_done_a: assert property (@(posedge mclk) disable iff (rst)
    cycStart_q && clkEn |-> ##[1:40] cycDone)
    else $error("bus cycle never finished");
  // reset clears the timeout flag when it completes
  reset_clear_a: assert property (@(posedge mclk) disable iff (rst)
    st_q == S_NEXT && op == OP_RESET && idx_q == last_q && clkEn
    |=> !tmo_q)
    else $error("timeout flag survived reset");
  // busy only ends with done raised
  busy_done_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(busy_q) |-> done_q)
    else $error("busy dropped without done");
  // a refused program never strobes the flash
  prog_refuse_a: assert property (@(posedge mclk) disable iff (rst)
    st_q == S_ISSUE && progBad && idx_q == 3'd0 && clkEn
    |=> !cycStart_q)
    else $error("program of a zero to one was issued");
  // sector address carries only the sector field
  sector_addr_a: assert property (@(posedge mclk) disable iff (rst)
    op == OP_SECTOR_ERASE && idx_q == 3'd5 |->
    cycReq.addr[SECTOR_LSB-1:0] == 12'h000)
    else $error("sector erase address has low bits set");
endmodule : flash_command_ctl
`default_nettype wire

// ---- test/flash_device_model.sv ----
// Purpose: behavioural parallel NOR flash standing on the controller pins
// Assumes: 256 cells indexed by address bits 15:12 and 3:0
// Notes: forceTmo makes the next program run out of time on purpose
`timescale 1ns/100ps
`default_nettype none
module flash_device_model #(
  parameter int PROG_NS = 3000,
  parameter int ERASE_NS = 6000,
  parameter int SUSP_NS = 50,
  parameter logic [15:0] MAKER = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEVID = 16'h005A // arbitrary value
) (
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic byteN,
  input wire logic [19:0] addr,
  input wire logic [15:0] din,
  input wire logic forceTmo,
  output logic [15:0] pinOut
);
  logic [15:0] mem [256];
  logic [15:0] val, lastVal = 16'h0000, progVal;
  logic [19:0] aq, progAdr, u1, u2;
  logic [7:0] sect;
  logic busy = 1'b0, susp = 1'b0, auto = 1'b0, tmo = 1'b0;
  logic tog = 1'b0, ers = 1'b0, chip = 1'b0;
  int step = 0, left = 0;
  wire wrN = ceN | weN | ~oeN;
  wire rdN = ceN | oeN;

  function automatic logic [7:0] idx(input logic [19:0] a);
    return {a[15:12], a[3:0]};
  endfunction : idx

  initial for (int i = 0; i < 256; i++) mem[i] = {8'hC3, i[7:0]};
  // unlock addresses follow the width pin
  assign u1 = byteN ? 20'h00555 : 20'h00AAA;
  assign u2 = byteN ? 20'h002AA : 20'h00555;

  // read mux; a released bus shows the inverse so nothing passes by luck
  always @* begin
    if (auto) val = addr[7:0] == 8'h00 ? MAKER : addr[7:0] == 8'h01 ? DEVID : 16'h0000;
    else if (busy && !susp) val = {9'h000, tog, tmo, 5'h00};
    else if (susp && addr[19:12] == sect) val = 16'h0080;
    else val = mem[idx(addr)];
  end
  assign pinOut = rdN ? ~lastVal : val;
  always @(negedge rdN) if (busy && !susp) tog = ~tog;
  always @(posedge rdN) lastVal <= val;
  always @(negedge wrN) aq = addr;
  always @(posedge wrN) cmd(aq, din);

  // embedded timer, frozen while suspended or failed
  always #10 begin
    if (busy && !susp && !tmo) left = left - 10;
    if (busy && !susp && !tmo && left <= 0) complete();
  end

  task automatic complete;
    if (forceTmo && !ers) tmo = 1'b1;
    else if (!ers) mem[idx(progAdr)] = mem[idx(progAdr)] & progVal;
    else for (int i = 0; i < 256; i++) if (chip || i[7:4] == sect[3:0]) mem[i] = 16'hFFFF;
    if (!tmo) busy = 1'b0;
  endtask : complete

  task automatic cmd(input logic [19:0] a, input logic [15:0] d);
    logic ok;
    if (tmo) begin
      if (d[7:0] == 8'hF0) {tmo, busy} = 2'b00;
      return;
    end
    if (susp) begin
      if (d[7:0] == 8'h30) susp = 1'b0;
      return;
    end
    if (busy) begin
      if (d[7:0] == 8'hB0 && ers && !chip) #(SUSP_NS) susp = 1'b1;
      return;
    end
    if (d[7:0] == 8'hF0) {auto, step} = 0;
    if (auto || d[7:0] == 8'hF0) return;
    if (step == 10) begin
      progAdr = a;
      progVal = byteN ? d : {8'hFF, d[7:0]};
      {ers, chip, step, left, busy} = {2'b00, 32'd0, PROG_NS, 1'b1};
      return;
    end
    case (step)
      0, 3: ok = a == u1 && d[7:0] == 8'hAA;
      1, 4: ok = a == u2 && d[7:0] == 8'h55;
      2: ok = a == u1 && d[7:0] inside {8'h90, 8'hA0, 8'h80};
      default: ok = (a == u1 && d[7:0] == 8'h10) || d[7:0] == 8'h30;
    endcase
    if (!ok) step = 0;
    else if (step == 2 && d[7:0] == 8'h90) {auto, step} = {1'b1, 32'd0};
    else if (step == 2 && d[7:0] == 8'hA0) step = 10;
    else if (step == 5) begin
      chip = d[7:0] == 8'h10;
      sect = a[19:12];
      {ers, step, left, busy} = {1'b1, 32'd0, ERASE_NS, 1'b1};
    end
    else step++;
  endtask : cmd
endmodule : flash_device_model
`default_nettype wire

// ---- test/flash_command_state_machine_bench.sv ----
// Purpose: self-checking bench for the AHB-Lite flash command controller
// Assumes: zero-wait slave, behavioural flash on the pins
// Notes: short embedded times and suspend wait keep the run brief
`timescale 1ns/100ps
`default_nettype none
module flash_command_state_machine_bench;
  import flash_ctl_pkg::*;
  localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
  localparam logic [15:0] DEVID = 16'h005A; // arbitrary value
  localparam logic [19:0] PGM = 20'h02005, BPG = 20'h02006, TPG = 20'h01007;
  logic mclk = 1'b0, rst = 1'b1, hwrite = 1'b0, forceTmo = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, st, v;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [15:0] flashDin, pinOut;
  flash_pins_t flashPins;
  int badCount = 0, samplesChecked = 0;

  always #5 mclk = ~mclk;
  // data pins: whoever enables drives them
  assign flashDin = flashPins.doutEnN ? pinOut : flashPins.dout;
  flash_command_ctl #(.SUSPEND_WAIT(10)) i_dut (.mclk(mclk), .rst(rst),
    .clkEn(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flashDin(flashDin), .flashPins(flashPins));
  flash_device_model #(.MAKER(MAKER), .DEVID(DEVID)) i_flash (
    .ceN(flashPins.ceN), .weN(flashPins.weN), .oeN(flashPins.oeN),
    .byteN(flashPins.byteN), .addr(flashPins.addr), .din(flashDin),
    .forceTmo(forceTmo), .pinOut(pinOut));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer; waits on hready, never on a cycle count
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic run(input op_t o, input logic [19:0] a, input logic [15:0] d,
                     input logic bm, output logic [31:0] s);
    logic [31:0] x;
    ahb(1'b1, OFS_ADDR, {12'h0, a}, x);
    ahb(1'b1, OFS_DATA, {16'h0, d}, x);
    ahb(1'b1, OFS_CTRL, {23'h0, bm, 4'(o), 3'h0, 1'b1}, x);
    s = 32'h1;
    for (int i = 0; i < 3000 && s[STAT_BUSY] !== 1'b0; i++) ahb(1'b0, OFS_STAT, 32'h0, s);
  endtask : run

  task automatic rdf(input logic [19:0] a, input logic bm, input logic [31:0] e);
    logic [31:0] s;
    run(OP_READ, a, 16'h0, bm, s);
    ahb(1'b0, OFS_RDAT, 32'h0, s);
    chk(bm ? {24'h0, s[7:0]} : s, e);
  endtask : rdf

  // power-up contents differ per cell so a wrong cell shows
  function automatic logic [31:0] init(input logic [19:0] a);
    return {16'h0, 8'hC3, a[15:12], a[3:0]};
  endfunction : init

  task automatic t_power;
    ahb(1'b0, OFS_STAT, 32'h0, st);
    chk(st, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b0, 8'h20, 32'h0, v);
    chk(v, 32'h0);
    rdf(20'h01002, 1'b0, init(20'h01002));
    $display("test power-up finished");
  endtask : t_power

  task automatic t_prog;
    rdf(PGM, 1'b0, init(PGM));
    run(OP_PROGRAM, PGM, 16'h4305, 1'b0, st);
    run(OP_POLL, PGM, 16'h0, 1'b0, st);
    chk({28'h0, st[3:0]}, 32'h2);
    rdf(PGM, 1'b0, 32'h4305);
    run(OP_PROGRAM, PGM, 16'hFFFF, 1'b0, st);
    chk({31'h0, st[STAT_ERR]}, 32'h1);
    $display("test word program finished");
  endtask : t_prog

  task automatic t_byte;
    rdf(BPG, 1'b1, 32'h26);
    run(OP_PROGRAM, BPG, 16'h0004, 1'b1, st);
    run(OP_POLL, BPG, 16'h0, 1'b1, st);
    rdf(BPG, 1'b1, 32'h04);
    rdf(BPG, 1'b0, 32'hC304);
    $display("test byte program finished");
  endtask : t_byte

  task automatic t_tmo;
    forceTmo <= 1'b1;
    rdf(TPG, 1'b0, init(TPG));
    run(OP_PROGRAM, TPG, 16'h0001, 1'b0, st);
    run(OP_POLL, TPG, 16'h0, 1'b0, st);
    chk({31'h0, st[STAT_TMO]}, 32'h1);
    forceTmo <= 1'b0;
    run(OP_RESET, 20'h12345, 16'h0, 1'b0, st);
    chk({31'h0, st[STAT_TMO]}, 32'h0);
    rdf(TPG, 1'b0, init(TPG));
    $display("test program timeout finished");
  endtask : t_tmo

  task automatic t_auto;
    run(OP_AUTOSEL, 20'h0, 16'h0, 1'b0, st);
    rdf(20'h00000, 1'b0, {16'h0, MAKER});
    rdf(20'h00001, 1'b0, {16'h0, DEVID});
    rdf(20'h00000, 1'b0, {16'h0, MAKER});
    run(OP_RESET, 20'h0, 16'h0, 1'b0, st);
    rdf(TPG, 1'b0, init(TPG));
    $display("test autoselect finished");
  endtask : t_auto

  task automatic t_sect;
    run(OP_SECTOR_ERASE, 20'h03ABC, 16'h0, 1'b0, st);
    run(OP_SUSPEND, 20'h55555, 16'h0, 1'b0, st);
    rdf(20'h03001, 1'b0, 32'h0080);
    rdf(20'h04001, 1'b0, init(20'h04001));
    run(OP_RESUME, 20'h0, 16'h0, 1'b0, st);
    run(OP_POLL, 20'h03001, 16'h0, 1'b0, st);
    rdf(20'h03001, 1'b0, 32'hFFFF);
    rdf(20'h03FFF, 1'b0, 32'hFFFF);
    rdf(20'h04001, 1'b0, init(20'h04001));
    $display("test sector erase finished");
  endtask : t_sect

  task automatic t_chip;
    run(OP_CHIP_ERASE, 20'h0, 16'h0, 1'b0, st);
    run(OP_SUSPEND, 20'h0, 16'h0, 1'b0, st);
    run(OP_POLL, PGM, 16'h0, 1'b0, st);
    rdf(PGM, 1'b0, 32'hFFFF);
    rdf(20'h04001, 1'b0, 32'hFFFF);
    $display("test chip erase finished");
  endtask : t_chip

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_power;
    t_prog;
    t_byte;
    t_tmo;
    t_auto;
    t_sect;
    t_chip;
    conclude;
  end

  // the tests need some 3.3k cycles; thirty times that means a hang
  initial begin
    #1_000_000;
    badCount++;
    conclude;
  end
endmodule : flash_command_state_machine_bench
`default_nettype wire
